// ===== bench/fst_timer_chk.sv
// assertion checker on the ports of the system tick counter
`timescale 1ns/1ps
`default_nettype none
`include "fst_regs.vh"
module fst_timer_chk (
   input wire logic                   core_clk,
   input wire logic                   rstn,
   input wire logic                   watchdog_reset,
   input wire logic                   soft_reset,
   input wire logic                   timer_soft_reset_request,
   input wire logic                   hardware_reset_pin_n,
   input wire logic [`FST_ADDR_W-1:0] avs_address,
   input wire logic                   avs_read,
   input wire logic                   avs_write,
   input wire logic [31:0]            avs_readdata,
   input wire logic                   avs_waitrequest,
   input wire logic                   irq
);
   wire         tmr_rst = watchdog_reset
                        | (soft_reset & timer_soft_reset_request);
   wire         rd_done = avs_read & ~avs_waitrequest;
   wire         win0_rd = rd_done && avs_address == `FST_OFS_WIN0;
   logic [31:0] last_q;
   logic        vld_q;
   logic [7:0]  since_q;
   logic [5:0]  pin_h_q;

   // reads straddling a timer reset are not covered by the count helpers
   always @(posedge core_clk or negedge rstn)
      if (!rstn)
      begin
         last_q  <= 32'h0000_0000;
         vld_q   <= 1'b0;
         since_q <= 8'h00;
         pin_h_q <= 6'h00;
      end
      else
      begin
         vld_q   <= !tmr_rst && (vld_q || win0_rd);
         last_q  <= win0_rd ? avs_readdata : last_q;
         since_q <= tmr_rst ? 8'h00 : since_q + {7'h00, since_q != 8'hFF};
         pin_h_q <= {pin_h_q[4:0], ~hardware_reset_pin_n};
      end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   wait_one_a: assert property (
      $rose(avs_read | avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer not after one wait cycle");
   rd_hold_a: assert property (
      !avs_read |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   win_high_a: assert property (
      rd_done && (avs_address == `FST_OFS_WIN6
                  || avs_address == `FST_OFS_CAP)
      |-> avs_readdata[31:24] == 8'h00)
      else $error("top byte of high window not zero");
   unmapped_zero_a: assert property (
      rd_done && avs_address == 8'hFC |-> avs_readdata == 32'h0000_0000)
      else $error("unmapped read not zero");
   cnt_mono_a: assert property (
      win0_rd && vld_q |-> avs_readdata >= last_q)
      else $error("counter went backwards");
   cnt_bound_a: assert property (
      win0_rd && since_q != 8'hFF |-> avs_readdata <= {24'h00_0000, since_q})
      else $error("counter ahead of time since reset");
   rst_irq_a: assert property (tmr_rst |=> !irq)
      else $error("irq high after timer reset");
   irq_fall_a: assert property (
      $fell(irq) |-> $past(avs_write && !avs_waitrequest)
                     || $past(tmr_rst) || |pin_h_q)
      else $error("irq fell without a clear");

   cover property (win0_rd && vld_q);
   cover property (tmr_rst);
   cover property ($fell(irq));
endmodule

bind fst_timer fst_timer_chk u_chk (
   .core_clk(core_clk), .rstn(rstn), .watchdog_reset(watchdog_reset),
   .soft_reset(soft_reset),
   .timer_soft_reset_request(timer_soft_reset_request),
   .hardware_reset_pin_n(hardware_reset_pin_n), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest), .irq(irq)
);
`default_nettype wire

// ===== bench/fst_timer_tb.sv
// self-checking bench for the system tick counter
`timescale 1ns/1ps
`default_nettype none
`include "fst_regs.vh"
module fst_timer_tb;
   logic        core_clk, rstn, wdg, srst, sreq, pin_n, dbg, rd, wr;
   logic [7:0]  adr;
   logic [31:0] wd, rdat, v, h, mk, rng;
   wire  [31:0] rdq;
   wire         wreq, irq;
   int          failures, n_checks;
   logic [31:0] exp_q[$], msk_q[$];
   logic [31:0] cfg [6] = '{32'h0000_0001, 32'h0000_0002, 32'h0000_0004,
                            32'h0000_0000, 32'h0000_0011, 32'h0000_0009};
   logic [31:0] clcx [6] = '{32'h0000_0101, 32'h0000_0102, 32'h0000_0104,
                             32'h0000_0000, 32'h0000_0211, 32'h0000_0009};
   // 12 cycles hold whole periods of dividers 1, 2 and 4
   int          dif [6] = '{12, 6, 3, 0, 0, 0};

   fst_timer uut (
      .core_clk(core_clk), .rstn(rstn), .watchdog_reset(wdg),
      .soft_reset(srst), .timer_soft_reset_request(sreq),
      .hardware_reset_pin_n(pin_n), .debug_suspend(dbg),
      .avs_address(adr), .avs_read(rd), .avs_write(wr),
      .avs_writedata(wd), .avs_byteenable(4'hF),
      .avs_readdata(rdq), .avs_waitrequest(wreq), .irq(irq)
   );

   function automatic logic [31:0] xs();
      rng = rng ^ (rng << 13);
      rng = rng ^ (rng >> 17);
      rng = rng ^ (rng << 5);
      return rng;
   endfunction

   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e)
      begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   // holds the request until waitrequest is seen low; no fixed latency
   task automatic acc(logic w, logic [7:0] a, logic [31:0] d);
      rd <= !w;
      wr <= w;
      adr <= a;
      wd <= d;
      @(posedge core_clk);
      while (wreq !== 1'b0)
         @(posedge core_clk);
      rdat = rdq;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic rdc(logic [7:0] a, logic [31:0] e, logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      acc(1'b0, a, '0);
   endtask

   task automatic wt(logic [7:0] a, logic [31:0] d);
      acc(1'b1, a, d);
   endtask

   task automatic irqc(logic e);
      repeat (3) @(posedge core_clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // a zero mask marks a read whose value only seeds a later note
   always @(posedge core_clk)
      if (rd && wreq === 1'b0)
      begin
         mk = msk_q.pop_front();
         chk("readdata", exp_q.pop_front() & mk, rdq & mk);
      end

   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   initial
   begin
      #200_000;
      failures++;
      report_and_stop();
   end

   initial
   begin
      {rstn, wdg, srst, sreq, dbg, rd, wr} = 7'h00;
      pin_n = 1'b1;
      adr = 8'h00;
      wd = '0;
      rng = 32'h0000_0027;
      repeat (12) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      rdc(`FST_OFS_CLC, 32'h0000_0102, 32'h0000_031F);
      wt(8'hFC, xs());
      rdc(8'hFC, '0, '1);
      $display("test reset done");
      dbg <= 1'b1;
      for (int i = 0; i < 6; i++)
      begin
         wt(`FST_OFS_CLC, cfg[i]);
         rdc(`FST_OFS_CLC, clcx[i], 32'h0000_031F);
         rdc(`FST_OFS_WIN0, '0, '0);
         repeat (9) @(posedge core_clk);
         rdc(`FST_OFS_WIN0, rdat + dif[i], '1);
      end
      dbg <= 1'b0;
      $display("test rate done");
      wt(`FST_OFS_CLC, '0);
      rdc(`FST_OFS_WIN0, '0, '0);
      v = rdat;
      rdc(`FST_OFS_CAP, '0, '0);
      h = rdat;
      wt(`FST_OFS_WIN0, xs());
      wt(`FST_OFS_CAP, xs());
      for (int k = 0; k < 6; k++)
         rdc(`FST_OFS_WIN0 + 4 * k, {h[23:0], v} >> (4 * k), '1);
      rdc(`FST_OFS_WIN6, {8'h00, h[23:0]}, '1);
      rdc(`FST_OFS_CAP, {8'h00, h[23:0]}, '1);
      $display("test windows done");
      pin_n <= 1'b0;
      repeat (6) @(posedge core_clk);
      pin_n <= 1'b1;
      repeat (6) @(posedge core_clk);
      rdc(`FST_OFS_CLC, '0, 32'h0000_031F);
      rdc(`FST_OFS_WIN0, v, '1);
      $display("test pin done");
      for (int q = 0; q < 3; q++)
      begin
         repeat (20) @(posedge core_clk);
         wdg <= (q == 0);
         srst <= (q > 0);
         sreq <= (q == 2);
         @(posedge core_clk);
         wdg <= 1'b0;
         srst <= 1'b0;
         rdc(`FST_OFS_WIN0, '0, '0);
         chk("cleared", q != 1, rdat <= 32'h0000_0002);
      end
      $display("test timer reset done");
      wt(`FST_OFS_CLC, '0);
      rdc(`FST_OFS_WIN0, '0, '0);
      v = rdat;
      wt(`FST_OFS_CMP0, ~v);
      wt(`FST_OFS_CMP1, xs() & 32'hFFFF_FFF0 | {28'h0, ~v[7:4]});
      wt(`FST_OFS_CMCON, 32'h0403_001F);
      wt(`FST_OFS_STAT, 32'h0000_0003);
      wt(`FST_OFS_MASK, 32'h0000_0003);
      irqc(1'b0);
      wt(`FST_OFS_CMP0, v);
      irqc(1'b1);
      rdc(`FST_OFS_STAT, 32'h0000_0001, 32'h0000_0003);
      wt(`FST_OFS_MASK, 32'h0000_0002);
      irqc(1'b0);
      wt(`FST_OFS_CMP1, xs() & 32'hFFFF_FFF0 | {28'h0, v[7:4]});
      irqc(1'b1);
      rdc(`FST_OFS_STAT, 32'h0000_0003, 32'h0000_0003);
      wt(`FST_OFS_STAT, 32'h0000_0002);
      irqc(1'b0);
      rdc(`FST_OFS_STAT, 32'h0000_0001, 32'h0000_0003);
      $display("test compare done");
      report_and_stop();
   end
endmodule
`default_nettype wire

// ===== src/fst_cmp_unit.v
// partial compare of the tick counter against one compare value
`timescale 1ns/1ps
`default_nettype none
`include "fst_regs.vh"

module fst_cmp_unit #(
   parameter CNT_W = `FST_CNT_W
)(
   input  wire [CNT_W-1:0]     count,
   input  wire [31:0]          cmp_val,
   input  wire [`FST_CMF_W-1:0] mstart,
   input  wire [`FST_CMF_W-1:0] msize,
   output wire                 match
);

   wire [CNT_W-1:0] shifted;
   wire [31:0]      field;
   wire [31:0]      mask;

   // mstart picks the lowest counter bit, msize+1 bits take part (R10)
   assign shifted = count >> mstart;
   assign field   = shifted[31:0];

   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1)
      begin : g_mask
         localparam [`FST_CMF_W-1:0] IDX = i;
         assign mask[i] = (IDX <= msize);
      end
   endgenerate

   assign match = (((field ^ cmp_val) & mask) == 32'h0000_0000); // R9

endmodule
`default_nettype wire

// ===== src/fst_regs.vh
// register map, field layout and reset values of the system tick counter
`ifndef FST_REGS_VH
`define FST_REGS_VH

`define FST_ADDR_W       8
`define FST_CNT_W        56
`define FST_DIV_W        3

`define FST_OFS_CLC      8'h00
`define FST_OFS_WIN0     8'h10
`define FST_OFS_WIN6     8'h28
`define FST_OFS_CAP      8'h2C
`define FST_OFS_CMP0     8'h30
`define FST_OFS_CMP1     8'h34
`define FST_OFS_CMCON    8'h38
`define FST_OFS_STAT     8'h3C
`define FST_OFS_MASK     8'h40

`define FST_WIN_CNT      7
`define FST_WIN_STEP     4
`define FST_WIN_LOW_CNT  6

`define FST_CLC_DIV_LSB  0
`define FST_CLC_DIS_BIT  3
`define FST_CLC_SUSP_BIT 4
`define FST_CLC_RUN_BIT  8
`define FST_CLC_HALT_BIT 9
`define FST_DIV_RST      3'h2

`define FST_CMF_W        5
`define FST_MSIZE0_LSB   0
`define FST_MSTART0_LSB  8
`define FST_MSIZE1_LSB   16
`define FST_MSTART1_LSB  24
`define FST_CMCON_RST    32'h001F_001F

`define FST_IRQ_CMP0_BIT 0
`define FST_IRQ_CMP1_BIT 1
`define FST_CMP_CNT      2

`endif

// ===== src/fst_timer.v
// free-running 56-bit system tick counter with Avalon-MM register slave
//
// Summary of operation
// (R1) 56-bit counter increments by one on every divided timer tick.
// (R2) timer tick is system clock divided by 3-bit field; reset value 2.
// (R3) power-on, watchdog or flagged soft reset clear counter; it restarts.
// (R4) hardware reset pin leaves counter and divider field untouched.
// (R5) counter, windows, capture read-only; writes to them are ignored.
// (R6) counter can be disabled or debug-suspended; registers stay readable.
// (R7) reading windows 0 to 5 latches counter high part into capture.
// (R8) seven 32-bit read windows cover ever higher counter bit ranges.
// (R9) counter compared with two stored values; a match can interrupt.
// (R10) each compare uses only a selectable slice of the counter.
// (R11) divider field 1 runs the counter at the full system clock.
// (R12) window n gives bits 4n+31..4n; window 6 and capture give 55..32.
// (R13) divider field zero stops the timer tick.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
`include "fst_regs.vh"

module fst_timer #(
   parameter CNT_W = `FST_CNT_W,
   parameter DIV_W = `FST_DIV_W
)(
   input  wire                   core_clk,
   input  wire                   rstn,
   input  wire                   watchdog_reset,
   input  wire                   soft_reset,
   input  wire                   timer_soft_reset_request,
   input  wire                   hardware_reset_pin_n,
   input  wire                   debug_suspend,
   input  wire [`FST_ADDR_W-1:0] avs_address,
   input  wire                   avs_read,
   input  wire                   avs_write,
   input  wire [31:0]            avs_writedata,
   input  wire [3:0]             avs_byteenable,
   output reg  [31:0]            avs_readdata,
   output wire                   avs_waitrequest,
   output wire                   irq
);

   // ---- synchronous reset sources
   reg  hw_pin_s1_q;
   reg  hw_pin_s2_q;
   wire hw_rst;
   wire tmr_clr;

   // watchdog and flagged soft reset come from the reset unit, same clock
   assign tmr_clr = watchdog_reset |
                    (soft_reset & timer_soft_reset_request); // R3

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         hw_pin_s1_q <= 1'b1;
         hw_pin_s2_q <= 1'b1;
      end
      else
      begin
         hw_pin_s1_q <= hardware_reset_pin_n;
         hw_pin_s2_q <= hw_pin_s1_q;
      end
   end

   assign hw_rst = ~hw_pin_s2_q;

   // ---- bus handshake: one wait cycle, then the answer
   reg          ack_q;
   wire         acc;
   wire         rd_take;
   wire         wr_take;
   wire [7:0]   win_off;
   wire [2:0]   win_idx;
   wire         is_win;

   assign acc             = avs_read | avs_write;
   assign avs_waitrequest = acc & ~ack_q;
   assign rd_take         = avs_read & ~ack_q;
   assign wr_take         = avs_write & ack_q;

   assign win_off = avs_address - `FST_OFS_WIN0;
   assign win_idx = win_off[4:2];
   assign is_win  = (avs_address >= `FST_OFS_WIN0) &&
                    (avs_address <= `FST_OFS_WIN6) &&
                    (avs_address[1:0] == 2'h0);

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         ack_q <= 1'b0;
      else
         ack_q <= acc & ~ack_q;
   end

   function [31:0] be_merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  be;
      integer      k;
      begin
         be_merge = old_v;
         for (k = 0; k < 4; k = k + 1)
            if (be[k])
               be_merge[k*8 +: 8] = new_v[k*8 +: 8];
      end
   endfunction

   // ---- clock control register
   reg  [DIV_W-1:0] div_q;
   reg              dis_q;
   reg              susp_en_q;
   wire             halted;
   wire             running;
   wire [31:0]      clc_wr;

   assign clc_wr = be_merge({{(32-DIV_W-2){1'b0}}, susp_en_q, dis_q, div_q},
                            avs_writedata, avs_byteenable);

   // divider kept through the pin reset, restored by timer resets
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         div_q     <= `FST_DIV_RST; // R2
         dis_q     <= 1'b0;
         susp_en_q <= 1'b0;
      end
      else if (tmr_clr)
      begin
         div_q     <= `FST_DIV_RST; // R3
         dis_q     <= 1'b0;
         susp_en_q <= 1'b0;
      end
      else if (hw_rst)
      begin
         dis_q     <= 1'b0; // R4
         susp_en_q <= 1'b0;
      end
      else if (wr_take && avs_address == `FST_OFS_CLC)
      begin
         div_q     <= clc_wr[`FST_CLC_DIV_LSB +: DIV_W];
         dis_q     <= clc_wr[`FST_CLC_DIS_BIT];
         susp_en_q <= clc_wr[`FST_CLC_SUSP_BIT];
      end
   end

   assign halted  = susp_en_q & debug_suspend; // R6
   assign running = (div_q != {DIV_W{1'b0}}) & ~dis_q & ~halted; // R13

   // ---- divider and counter
   reg  [DIV_W-1:0] div_cnt_q;
   reg  [CNT_W-1:0] cnt_q;
   wire [DIV_W-1:0] div_last;
   wire             tick;

   assign div_last = div_q - {{(DIV_W-1){1'b0}}, 1'b1};
   // >= recovers at once when the divider is lowered mid-count
   assign tick     = running && (div_cnt_q >= div_last); // R11

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         div_cnt_q <= {DIV_W{1'b0}};
      else if (tmr_clr || tick || !running)
         div_cnt_q <= {DIV_W{1'b0}};
      else
         div_cnt_q <= div_cnt_q + {{(DIV_W-1){1'b0}}, 1'b1};
   end

   // no bus path writes the counter; pin reset is deliberately absent
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cnt_q <= {CNT_W{1'b0}};
      else if (tmr_clr)
         cnt_q <= {CNT_W{1'b0}}; // R3
      else if (tick)
         cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}; // R1
   end

   // ---- read windows and capture
   reg  [CNT_W-33:0] cap_q;
   wire [31:0]       win_w [0:`FST_WIN_CNT-1];

   genvar n;
   generate
      for (n = 0; n < `FST_WIN_LOW_CNT; n = n + 1)
      begin : g_win
         assign win_w[n] = cnt_q[n*`FST_WIN_STEP +: 32]; // R12
      end
   endgenerate

   assign win_w[`FST_WIN_LOW_CNT] = {{(64-CNT_W){1'b0}}, cnt_q[CNT_W-1:32]};

   // high part frozen in the same cycle the low slice is sampled
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cap_q <= {(CNT_W-32){1'b0}};
      else if (tmr_clr)
         cap_q <= {(CNT_W-32){1'b0}};
      else if (rd_take && is_win && win_idx < `FST_WIN_LOW_CNT)
         cap_q <= cnt_q[CNT_W-1:32]; // R7
   end

   // ---- compare units and interrupt
   wire [31:0]     cmp_w [0:`FST_CMP_CNT-1];
   reg  [31:0]     cmcon_q;
   reg  [1:0]      stat_q;
   reg  [1:0]      mask_q;
   wire [1:0]      evt;
   wire [31:0]     cmcon_wr;
   wire [31:0]     stat_wr;
   wire [31:0]     mask_wr;
   wire [1:0]      stat_clr;

   assign cmcon_wr = be_merge(cmcon_q, avs_writedata, avs_byteenable);
   assign stat_wr  = be_merge(32'h0000_0000, avs_writedata, avs_byteenable);
   assign mask_wr  = be_merge({30'h0000_0000, mask_q}, avs_writedata,
                              avs_byteenable);

   genvar c;
   generate
      for (c = 0; c < `FST_CMP_CNT; c = c + 1)
      begin : g_cmp
         localparam [7:0] OFS = (c == 0) ? `FST_OFS_CMP0 : `FST_OFS_CMP1;
         localparam ST_LSB = (c == 0) ? `FST_MSTART0_LSB : `FST_MSTART1_LSB;
         localparam SZ_LSB = (c == 0) ? `FST_MSIZE0_LSB : `FST_MSIZE1_LSB;
         wire        match;
         reg         match_q;
         reg  [31:0] val_q;

         fst_cmp_unit #(
            .CNT_W (CNT_W)
         ) u_cmp (
            .count   (cnt_q),
            .cmp_val (val_q),
            .mstart  (cmcon_q[ST_LSB +: `FST_CMF_W]),
            .msize   (cmcon_q[SZ_LSB +: `FST_CMF_W]),
            .match   (match)
         );

         always @(posedge core_clk or negedge rstn)
         begin
            if (!rstn)
               val_q <= 32'h0000_0000;
            else if (tmr_clr || hw_rst)
               val_q <= 32'h0000_0000;
            else if (wr_take && avs_address == OFS)
               val_q <= be_merge(val_q, avs_writedata, avs_byteenable);
         end

         assign cmp_w[c] = val_q;

         // a match lasts many ticks; only its start is an event
         always @(posedge core_clk or negedge rstn)
         begin
            if (!rstn)
               match_q <= 1'b0;
            else
               match_q <= match;
         end

         assign evt[c] = match & ~match_q; // R9
      end
   endgenerate

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         cmcon_q <= `FST_CMCON_RST;
      else if (tmr_clr || hw_rst)
         cmcon_q <= `FST_CMCON_RST;
      else if (wr_take && avs_address == `FST_OFS_CMCON)
         cmcon_q <= cmcon_wr; // R10
   end

   assign stat_clr = (wr_take && avs_address == `FST_OFS_STAT) ?
                     stat_wr[1:0] : 2'h0;

   // a new event in the clearing cycle survives the clear
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         stat_q <= 2'h0;
      else if (tmr_clr || hw_rst)
         stat_q <= 2'h0;
      else
         stat_q <= (stat_q & ~stat_clr) | evt;
   end

   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         mask_q <= 2'h0;
      else if (tmr_clr || hw_rst)
         mask_q <= 2'h0;
      else if (wr_take && avs_address == `FST_OFS_MASK)
         mask_q <= mask_wr[1:0];
   end

   assign irq = |(stat_q & mask_q);

   // ---- read data, sampled on the first cycle of the access
   reg [31:0] rd_d;

   always @*
   begin
      rd_d = 32'h0000_0000;
      if (is_win)
         rd_d = win_w[win_idx]; // R8
      else
      begin
         case (avs_address)
            `FST_OFS_CLC:
               rd_d = {22'h00_0000, halted, running, 3'h0,
                       susp_en_q, dis_q, div_q};
            `FST_OFS_CAP:
               rd_d = {{(64-CNT_W){1'b0}}, cap_q}; // R12
            `FST_OFS_CMP0:
               rd_d = cmp_w[0];
            `FST_OFS_CMP1:
               rd_d = cmp_w[1];
            `FST_OFS_CMCON:
               rd_d = cmcon_q;
            `FST_OFS_STAT:
               rd_d = {30'h0000_0000, stat_q};
            `FST_OFS_MASK:
               rd_d = {30'h0000_0000, mask_q};
            default:
               rd_d = 32'h0000_0000;
         endcase
      end
   end

   // windows and capture have no write path at all
   always @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
         avs_readdata <= 32'h0000_0000;
      else if (rd_take)
         avs_readdata <= rd_d; // R5
   end

endmodule
`default_nettype wire
